// ===== common/tpwm_defines.svh
// Register map, field positions and reset values of the three-phase PWM timing unit
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define TPWM_OFF_HALF_PERIOD   12'h000
`define TPWM_OFF_DEAD_TIME     12'h004
`define TPWM_OFF_MIN_PULSE     12'h008
`define TPWM_OFF_SYNC_WIDTH    12'h00C
`define TPWM_OFF_MODE_CTRL     12'h010
`define TPWM_OFF_SYS_STATUS    12'h014
`define TPWM_OFF_DUTY_A        12'h018
`define TPWM_OFF_DUTY_B        12'h01C
`define TPWM_OFF_DUTY_C        12'h020
`define TPWM_OFF_SEGMENT       12'h024

// ==========================================================================
// Field positions
`define TPWM_MODE_DOUBLE_BIT   6
`define TPWM_STAT_HALF_BIT     3

// ==========================================================================
// Reset values
`define TPWM_RST_HALF_PERIOD   16'h0000
`define TPWM_RST_DEAD_TIME     10'h000
`define TPWM_RST_MIN_PULSE     16'h0000
`define TPWM_RST_SYNC_WIDTH    8'h27
`define TPWM_RST_DUTY          16'h0000
`define TPWM_RST_SEGMENT       9'h000

`endif

// ===== common/tpwm_pkg.sv
// Types shared by the three-phase PWM timing unit
package tpwm_pkg;

  // Timing core sequencing states
  typedef enum logic [2:0] {
    TPWM_IDLE  = 3'b001,
    TPWM_UP    = 3'b010,
    TPWM_DOWN  = 3'b100
  } tpwm_state_t;

endpackage : tpwm_pkg

// ===== hdl/tpwm_phase.sv
// One complementary output pair with dead-time insertion
`timescale 1ns/1ps

module tpwm_phase #(
  parameter int CW = 16,
  parameter int DW = 10
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Timing
  input  wire logic [CW-1:0] count,
  input  wire logic [CW-1:0] duty,
  input  wire logic [DW-1:0] dead,
  input  wire logic          run,
  // Active-low switch commands
  output logic               high_out_n,
  output logic               low_out_n
);

  // ==========================================================================
  // Window compare
  // The high switch is on while count < duty - dead; the low one while
  // count >= duty + dead. Both edges move by dead counts away from duty.
  logic [CW+1:0] hi_lim;
  logic [CW+1:0] lo_lim;
  logic          hi_on;
  logic          lo_on;

  assign hi_lim = {2'b00, duty} - {{(CW+2-DW){1'b0}}, dead};
  assign lo_lim = {2'b00, duty} + {{(CW+2-DW){1'b0}}, dead};
  // Underflow of hi_lim sets its top bit: no high pulse
  assign hi_on  = run && !hi_lim[CW+1] && ({2'b00, count} < hi_lim);
  assign lo_on  = run && ({2'b00, count} >= lo_lim);

  // ==========================================================================
  // Registered active-low outputs, both off in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_out_n <= 1'b1;
      low_out_n  <= 1'b1;
    end else begin
      high_out_n <= !hi_on;
      low_out_n  <= !lo_on;
    end
  end

endmodule : tpwm_phase

// ===== hdl/tpwm_timing_unit.sv
// Three-phase PWM timing unit with APB register slave
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "tpwm_defines.svh"

module tpwm_timing_unit #(
  parameter int CW = 16,
  parameter int DW = 10,
  parameter int SW = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Switch commands, active low
  output logic             phase_a_high_out,
  output logic             phase_a_low_out,
  output logic             phase_b_high_out,
  output logic             phase_b_low_out,
  output logic             phase_c_high_out,
  output logic             phase_c_low_out,
  // Synchronisation
  output logic             period_sync_pulse,
  output logic             sync_irq,
  // Latched values for downstream stages
  output logic      [8:0]  segment_latched,
  output logic      [CW-1:0] min_pulse_latched
);

  // ==========================================================================
  // Software-visible registers
  logic [CW-1:0] half_period_count_q;
  logic [DW-1:0] dead_time_count_q;
  logic [CW-1:0] min_pulse_width_q;
  logic [SW-1:0] sync_pulse_width_q;
  logic          mode_double_q;
  logic [CW-1:0] duty_phase_a_q;
  logic [CW-1:0] duty_phase_b_q;
  logic [CW-1:0] duty_phase_c_q;
  logic [8:0]    output_segment_ctrl_q;

  // Working copies
  logic [CW-1:0] wk_period_q;
  logic [DW-1:0] wk_dead_q;
  logic [SW-1:0] wk_sync_q;
  logic [CW-1:0] wk_duty_a_q;
  logic [CW-1:0] wk_duty_b_q;
  logic [CW-1:0] wk_duty_c_q;

  // Core state
  tpwm_pkg::tpwm_state_t state_q;
  logic [CW-1:0] count_q;
  logic          half_q;
  logic [SW:0]   sync_cnt_q;
  logic          latch_ev;
  logic          mid_ev;
  logic          start_ev;
  logic          run;
  logic          wr_en;
  logic          rd_en;
  logic          addr_ok;
  logic [CW-1:0] down_top;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `TPWM_OFF_HALF_PERIOD) || (a == `TPWM_OFF_DEAD_TIME) ||
               (a == `TPWM_OFF_MIN_PULSE)   || (a == `TPWM_OFF_SYNC_WIDTH) ||
               (a == `TPWM_OFF_MODE_CTRL)   || (a == `TPWM_OFF_SYS_STATUS) ||
               (a == `TPWM_OFF_DUTY_A)      || (a == `TPWM_OFF_DUTY_B) ||
               (a == `TPWM_OFF_DUTY_C)      || (a == `TPWM_OFF_SEGMENT);
  endfunction : addr_hit

  // ==========================================================================
  // APB decode: zero wait states, unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign addr_ok = addr_hit(paddr);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_period_count_q   <= `TPWM_RST_HALF_PERIOD;
      dead_time_count_q     <= `TPWM_RST_DEAD_TIME;
      min_pulse_width_q     <= `TPWM_RST_MIN_PULSE;
      sync_pulse_width_q    <= `TPWM_RST_SYNC_WIDTH;
      mode_double_q         <= 1'b0;
      duty_phase_a_q        <= `TPWM_RST_DUTY;
      duty_phase_b_q        <= `TPWM_RST_DUTY;
      duty_phase_c_q        <= `TPWM_RST_DUTY;
      output_segment_ctrl_q <= `TPWM_RST_SEGMENT;
    end else if (wr_en) begin
      unique case (paddr)
        `TPWM_OFF_HALF_PERIOD: half_period_count_q   <= pwdata[CW-1:0];
        `TPWM_OFF_DEAD_TIME:   dead_time_count_q     <= pwdata[DW-1:0];
        `TPWM_OFF_MIN_PULSE:   min_pulse_width_q     <= pwdata[CW-1:0];
        `TPWM_OFF_SYNC_WIDTH:  sync_pulse_width_q    <= pwdata[SW-1:0];
        `TPWM_OFF_MODE_CTRL:   mode_double_q         <= pwdata[`TPWM_MODE_DOUBLE_BIT];
        `TPWM_OFF_DUTY_A:      duty_phase_a_q        <= pwdata[CW-1:0];
        `TPWM_OFF_DUTY_B:      duty_phase_b_q        <= pwdata[CW-1:0];
        `TPWM_OFF_DUTY_C:      duty_phase_c_q        <= pwdata[CW-1:0];
        `TPWM_OFF_SEGMENT:     output_segment_ctrl_q <= pwdata[8:0];
        default: begin
        end
      endcase
    end
  end

  // Read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= 32'h00000000;
      unique case (paddr)
        `TPWM_OFF_HALF_PERIOD: prdata[CW-1:0] <= half_period_count_q;
        `TPWM_OFF_DEAD_TIME:   prdata[DW-1:0] <= dead_time_count_q;
        `TPWM_OFF_MIN_PULSE:   prdata[CW-1:0] <= min_pulse_width_q;
        `TPWM_OFF_SYNC_WIDTH:  prdata[SW-1:0] <= sync_pulse_width_q;
        `TPWM_OFF_MODE_CTRL:   prdata[`TPWM_MODE_DOUBLE_BIT] <= mode_double_q;
        `TPWM_OFF_SYS_STATUS:  prdata[`TPWM_STAT_HALF_BIT] <= half_q;
        `TPWM_OFF_DUTY_A:      prdata[CW-1:0] <= duty_phase_a_q;
        `TPWM_OFF_DUTY_B:      prdata[CW-1:0] <= duty_phase_b_q;
        `TPWM_OFF_DUTY_C:      prdata[CW-1:0] <= duty_phase_c_q;
        `TPWM_OFF_SEGMENT:     prdata[8:0] <= output_segment_ctrl_q;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Up/down counter: 0..N-1 up, N-1..0 down, one full period is 2N clocks
  // Every count shows once per half, so both halves give the same on-time.
  // A zero half period parks the core idle, outputs off, no sync.
  assign start_ev = (state_q == tpwm_pkg::TPWM_IDLE) ? (half_period_count_q != 16'h0000) :
                    ((state_q == tpwm_pkg::TPWM_DOWN) && (count_q == 16'h0000));
  assign mid_ev   = (state_q == tpwm_pkg::TPWM_UP) && (count_q + 16'h0001 >= wk_period_q);
  // Period start always latches; midpoint latches only in double update
  assign latch_ev = start_ev || (mid_ev && mode_double_q);
  assign run      = (state_q != tpwm_pkg::TPWM_IDLE);
  // Down half starts from the half period in force for it
  assign down_top = mode_double_q ? half_period_count_q : wk_period_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tpwm_pkg::TPWM_IDLE;
      count_q <= 16'h0000;
    end else begin
      unique case (state_q)
        tpwm_pkg::TPWM_IDLE: begin
          if (start_ev) begin
            state_q <= tpwm_pkg::TPWM_UP;
            count_q <= 16'h0000;
          end
        end
        tpwm_pkg::TPWM_UP: begin
          if (mid_ev) begin
            state_q <= tpwm_pkg::TPWM_DOWN;
            count_q <= (down_top == 16'h0000) ? 16'h0000 : down_top - 16'h0001;
          end else begin
            count_q <= count_q + 16'h0001;
          end
        end
        tpwm_pkg::TPWM_DOWN: begin
          if (start_ev) begin
            state_q <= (half_period_count_q == 16'h0000) ? tpwm_pkg::TPWM_IDLE : tpwm_pkg::TPWM_UP;
            count_q <= 16'h0000;
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // Half-cycle flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
    end else if (start_ev) begin
      half_q <= 1'b0;
    end else if (mid_ev) begin
      half_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Working copies loaded at every sync rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_period_q       <= `TPWM_RST_HALF_PERIOD;
      wk_dead_q         <= `TPWM_RST_DEAD_TIME;
      wk_sync_q         <= `TPWM_RST_SYNC_WIDTH;
      wk_duty_a_q       <= `TPWM_RST_DUTY;
      wk_duty_b_q       <= `TPWM_RST_DUTY;
      wk_duty_c_q       <= `TPWM_RST_DUTY;
      min_pulse_latched <= `TPWM_RST_MIN_PULSE;
      segment_latched   <= `TPWM_RST_SEGMENT;
    end else if (latch_ev) begin
      wk_period_q       <= half_period_count_q;
      wk_dead_q         <= dead_time_count_q;
      wk_sync_q         <= sync_pulse_width_q;
      wk_duty_a_q       <= duty_phase_a_q;
      wk_duty_b_q       <= duty_phase_b_q;
      wk_duty_c_q       <= duty_phase_c_q;
      min_pulse_latched <= min_pulse_width_q;
      segment_latched   <= output_segment_ctrl_q;
    end
  end

  // ==========================================================================
  // Sync pulse: high for width+1 clocks, interrupt pulse on its rise
  // Uses the width being latched so the new value takes effect at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt_q        <= 9'h000;
      period_sync_pulse <= 1'b0;
      sync_irq          <= 1'b0;
    end else begin
      sync_irq <= latch_ev;
      if (latch_ev) begin
        sync_cnt_q        <= {1'b0, sync_pulse_width_q};
        period_sync_pulse <= 1'b1;
      end else if (sync_cnt_q != 9'h000) begin
        sync_cnt_q <= sync_cnt_q - 9'h001;
      end else begin
        period_sync_pulse <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Output pairs; dead count applied on each side gives 2x dead clocks
  // between one switch off and the other on.
  logic [DW-1:0] dead_eff;
  assign dead_eff = wk_dead_q;

  tpwm_phase #(.CW(CW), .DW(DW)) u_phase_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .count      (count_q),
    .duty       (wk_duty_a_q),
    .dead       (dead_eff),
    .run        (run),
    .high_out_n (phase_a_high_out),
    .low_out_n  (phase_a_low_out)
  );

  tpwm_phase #(.CW(CW), .DW(DW)) u_phase_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .count      (count_q),
    .duty       (wk_duty_b_q),
    .dead       (dead_eff),
    .run        (run),
    .high_out_n (phase_b_high_out),
    .low_out_n  (phase_b_low_out)
  );

  tpwm_phase #(.CW(CW), .DW(DW)) u_phase_c (
    .pclk       (pclk),
    .presetn    (presetn),
    .count      (count_q),
    .duty       (wk_duty_c_q),
    .dead       (dead_eff),
    .run        (run),
    .high_out_n (phase_c_high_out),
    .low_out_n  (phase_c_low_out)
  );

endmodule : tpwm_timing_unit

// ===== testbench/tpwm_timing_unit_sva.sv
// Port-level assertions for the PWM timing unit
`timescale 1ns/1ps
`include "tpwm_defines.svh"

module tpwm_timing_unit_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Switch commands and sync
  input wire logic        phase_a_high_out,
  input wire logic        phase_a_low_out,
  input wire logic        phase_b_high_out,
  input wire logic        phase_b_low_out,
  input wire logic        phase_c_high_out,
  input wire logic        phase_c_low_out,
  input wire logic        period_sync_pulse,
  input wire logic        sync_irq
);
  // ====================
  // Width shadow, aged one edge so it is the value the core saw when it latched
  logic [7:0] sw_q;
  logic [7:0] sw1_q;
  logic [7:0] lat_q;
  logic [8:0] hi_q;
  logic       sync_q;
  logic       seen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q  <= 8'h27;
      sw1_q <= 8'h27;
      lat_q <= 8'h27;
    end else begin
      if (psel && penable && pwrite && paddr == `TPWM_OFF_SYNC_WIDTH) begin
        sw_q <= pwdata[7:0];
      end
      sw1_q <= sw_q;
      if (period_sync_pulse && !sync_q) begin
        lat_q <= sw1_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q   <= 9'h000;
      sync_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      hi_q   <= period_sync_pulse ? hi_q + 9'h001 : 9'h000;
      sync_q <= period_sync_pulse;
      seen_q <= seen_q | period_sync_pulse;
    end
  end

  // ====================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sync_rise;
    !period_sync_pulse ##1 period_sync_pulse;
  endsequence

  property p_irq_on_rise;
    s_sync_rise |-> sync_irq;
  endproperty
  a_irq_on_rise: assert property (p_irq_on_rise) else $error("no irq at sync rise");

  property p_irq_cause;
    sync_irq |-> $rose(period_sync_pulse);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without sync rise");

  property p_irq_once;
    sync_irq |=> !sync_irq;
  endproperty
  a_irq_once: assert property (p_irq_once) else $error("irq longer than one cycle");

  property p_sync_width;
    $fell(period_sync_pulse) |-> hi_q == {1'b0, lat_q} + 9'h001;
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync width wrong");

  property p_no_overlap;
    (phase_a_high_out || phase_a_low_out) && (phase_b_high_out || phase_b_low_out)
      && (phase_c_high_out || phase_c_low_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches of a pair on");

  property p_idle_off;
    !seen_q && !period_sync_pulse |-> phase_a_high_out && phase_a_low_out && phase_b_high_out
      && phase_b_low_out && phase_c_high_out && phase_c_low_out;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("switch on before first period");

  property p_unmapped;
    psel && penable && paddr > `TPWM_OFF_SEGMENT |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");

  property p_mapped_ok;
    psel && penable && paddr <= `TPWM_OFF_SEGMENT && paddr[1:0] == 2'b00 |-> !pslverr && pready;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("error on mapped access");
endmodule : tpwm_timing_unit_chk

bind tpwm_timing_unit tpwm_timing_unit_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .phase_a_high_out(phase_a_high_out), .phase_a_low_out(phase_a_low_out),
  .phase_b_high_out(phase_b_high_out), .phase_b_low_out(phase_b_low_out),
  .phase_c_high_out(phase_c_high_out), .phase_c_low_out(phase_c_low_out),
  .period_sync_pulse(period_sync_pulse), .sync_irq(sync_irq)
);

// ===== testbench/tpwm_gate_drive_model.sv
// Gate drive load model that measures switch on-times per sync interval
`timescale 1ns/1ps

module tpwm_gate_drive_model (
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // Commands, active low: ah al bh bl ch cl
  input wire logic [5:0]   cmd_n,
  input wire logic         sync,
  // Figures of the last complete sync interval
  output logic [5:0][31:0] on_cnt,
  output logic [31:0]      gap_cnt,
  output logic [31:0]      sync_width,
  output logic [31:0]      n_sync
);
  logic [5:0][31:0] acc_q;
  logic [31:0]      gap_q;
  logic [31:0]      hi_q;
  logic             sync_q;
  logic             sync_qq;

  // Windows open one clock after each sync rise: the commands lag the sync
  // by one register, so this measures one full interval whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= '0;
      gap_q   <= '0;
      on_cnt  <= '0;
      gap_cnt <= '0;
      n_sync  <= '0;
    end else if (sync_q && !sync_qq) begin
      on_cnt  <= acc_q;
      gap_cnt <= gap_q;
      n_sync  <= n_sync + 32'h1;
      gap_q   <= 32'h1;
      for (int i = 0; i < 6; i++) acc_q[i] <= {31'h0, ~cmd_n[i]};
    end else begin
      gap_q <= gap_q + 32'h1;
      for (int i = 0; i < 6; i++) acc_q[i] <= acc_q[i] + {31'h0, ~cmd_n[i]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q     <= 1'b0;
      sync_qq    <= 1'b0;
      hi_q       <= '0;
      sync_width <= '0;
    end else begin
      sync_q <= sync;
      sync_qq <= sync_q;
      hi_q   <= sync ? hi_q + 32'h1 : 32'h0;
      if (!sync && sync_q) begin
        sync_width <= hi_q;
      end
    end
  end
endmodule : tpwm_gate_drive_model

// ===== testbench/tpwm_timing_unit_test.sv
// Self-checking bench for the PWM timing unit
`timescale 1ns/1ps
`include "tpwm_defines.svh"
`define CHK(g, x) \
  begin \
    n_compared++; \
    if ((g) !== (x)) begin \
      miscompares++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, x); \
    end \
  end

module tpwm_timing_unit_test;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  wire  [5:0]       cmd_n;
  logic             sync;
  logic             irq;
  logic [8:0]       seg;
  logic [15:0]      minp;
  logic [5:0][31:0] on_cnt;
  logic [31:0]      gap_cnt;
  logic [31:0]      sync_width;
  logic [31:0]      n_sync;
  logic [31:0]      q;
  logic             e;
  int               miscompares;
  int               n_compared;
  int               cyc;

  tpwm_timing_unit i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_high_out(cmd_n[0]), .phase_a_low_out(cmd_n[1]), .phase_b_high_out(cmd_n[2]),
    .phase_b_low_out(cmd_n[3]), .phase_c_high_out(cmd_n[4]), .phase_c_low_out(cmd_n[5]),
    .period_sync_pulse(sync), .sync_irq(irq), .segment_latched(seg), .min_pulse_latched(minp)
  );

  tpwm_gate_drive_model i_load (
    .pclk(pclk), .presetn(presetn), .cmd_n(cmd_n), .sync(sync),
    .on_cnt(on_cnt), .gap_cnt(gap_cnt), .sync_width(sync_width), .n_sync(n_sync)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ====================
  // Bus and measurement tasks
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    `CHK(q, x)
  endtask : rd

  task automatic wait_syncs(input int k);
    logic [31:0] t;
    t = n_sync + 32'(k);
    while (n_sync < t) @(posedge pclk);
  endtask : wait_syncs

  function automatic logic [31:0] span(input int v, input int m);
    return 32'((v < 0 ? 0 : v) * m);
  endfunction : span

  // m is 2 for a full period per sync, 1 for a half period per sync
  task automatic chk_run(input int n, input int dt, input int da, input int db, input int dc,
                         input int w, input int m);
    int du [3];
    du = '{da, db, dc};
    wait_syncs(3);
    `CHK(gap_cnt, 32'(n * m))
    `CHK(sync_width, 32'(w + 1))
    for (int k = 0; k < 3; k++) begin
      `CHK(on_cnt[2*k], span(du[k] - dt, m))
      `CHK(on_cnt[2*k+1], span(n - du[k] - dt, m))
    end
  endtask : chk_run

  task automatic results();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Ceiling well above the roughly 1000 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end

  // ====================
  // Tests
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TPWM_OFF_SYNC_WIDTH, 32'h27);
    rd(`TPWM_OFF_MODE_CTRL, 32'h0);
    rd(`TPWM_OFF_SYS_STATUS, 32'h0);
    apb(12'h030, 1'b0, 32'h0);
    `CHK(e, 1'b1)
    `CHK(q, 32'h0)
    apb(`TPWM_OFF_SYS_STATUS, 1'b1, 32'hFFFFFFFF);
    `CHK(e, 1'b0)
    rd(`TPWM_OFF_SYS_STATUS, 32'h0);
    apb(`TPWM_OFF_DEAD_TIME, 1'b1, 32'hFFFFFFFF);
    rd(`TPWM_OFF_DEAD_TIME, 32'h3FF);
    apb(`TPWM_OFF_MODE_CTRL, 1'b1, 32'h40);
    rd(`TPWM_OFF_MODE_CTRL, 32'h40);
    apb(`TPWM_OFF_MODE_CTRL, 1'b1, 32'h0);
    $display("test registers done");
    // Half period written last, since a nonzero value starts the core
    apb(`TPWM_OFF_DEAD_TIME, 1'b1, 32'h3);
    apb(`TPWM_OFF_DUTY_A, 1'b1, 32'hA);
    apb(`TPWM_OFF_DUTY_B, 1'b1, 32'h14);
    apb(`TPWM_OFF_DUTY_C, 1'b1, 32'h28);
    apb(`TPWM_OFF_HALF_PERIOD, 1'b1, 32'h28);
    chk_run(40, 3, 10, 20, 40, 39, 2);
    wait_syncs(1);
    rd(`TPWM_OFF_SYS_STATUS, 32'h0);
    repeat (45) @(posedge pclk);
    rd(`TPWM_OFF_SYS_STATUS, 32'h8);
    $display("test single update done");
    wait_syncs(1);
    apb(`TPWM_OFF_SEGMENT, 1'b1, 32'h1A5);
    apb(`TPWM_OFF_MIN_PULSE, 1'b1, 32'h1234);
    apb(`TPWM_OFF_SYNC_WIDTH, 1'b1, 32'h0);
    apb(`TPWM_OFF_DEAD_TIME, 1'b1, 32'h0);
    apb(`TPWM_OFF_DUTY_A, 1'b1, 32'hF);
    `CHK(seg, 9'h000)
    chk_run(40, 0, 15, 20, 40, 0, 2);
    `CHK(seg, 9'h1A5)
    `CHK(minp, 16'h1234)
    $display("test latching done");
    apb(`TPWM_OFF_SYNC_WIDTH, 1'b1, 32'h9);
    apb(`TPWM_OFF_DEAD_TIME, 1'b1, 32'h3);
    apb(`TPWM_OFF_MODE_CTRL, 1'b1, 32'h40);
    chk_run(40, 3, 15, 20, 40, 9, 1);
    wait_syncs(1);
    apb(`TPWM_OFF_SEGMENT, 1'b1, 32'h5A);
    wait_syncs(1);
    `CHK(seg, 9'h05A)
    $display("test double update done");
    apb(`TPWM_OFF_HALF_PERIOD, 1'b1, 32'hFFFF);
    rd(`TPWM_OFF_HALF_PERIOD, 32'hFFFF);
    $display("test period range done");
    results();
  end
endmodule : tpwm_timing_unit_test
